// *** verilog/reg_codec_params.svh ***
// Constants for the registration message codec: offsets, fields, resets, encodings
`ifndef REG_CODEC_PARAMS_SVH
`define REG_CODEC_PARAMS_SVH

// Register byte offsets
`define OFS_CTRL       8'h00
`define OFS_DA_LO      8'h04
`define OFS_DA_HI      8'h08
`define OFS_SA_LO      8'h0C
`define OFS_SA_HI      8'h10
`define OFS_TX_FIELDS  8'h14
`define OFS_TX_SYNC    8'h18
`define OFS_TIMESTAMP  8'h1C
`define OFS_STATUS     8'h20
`define OFS_MASK       8'h24
`define OFS_RX_FIELDS  8'h28
`define OFS_RX_SYNC    8'h2C

// Control bits (write pulses)
`define CTRL_SEND_REG  0
`define CTRL_SEND_ACK  1

// Status and mask bit positions
`define ST_TX_DONE     0
`define ST_RX_REG      1
`define ST_RX_ACK      2
`define ST_RX_DEREG    3
`define ST_TX_REFUSED  4
`define ST_RX_BAD_DA   5
`define ST_WIDTH       6

// Reset values
`define RST_MASK       6'h00
`define RST_SYNC       16'h0000
`define RST_GRANTS     8'h00
`define RST_REG_FLAG   8'h03
`define RST_ACK_FLAG   8'h01

// Frame layout
`define MAC_CTRL_TYPE  16'h8808
`define OPC_REGISTER   16'h0005
`define OPC_REG_ACK    16'h0006
`define FRAME_LEN      6'd60
`define RX_MIN_LEN     6'd25
`define BCAST_LLID     16'h7FFF

// Flag encodings
`define RF_REREG       8'h01
`define RF_DEREG       8'h02
`define RF_ACK         8'h03
`define RF_NACK        8'h04
`define AF_NACK        8'h00
`define AF_ACK         8'h01

// Receiver lock needs, in 16 bit time increments
`define LOCK_PMD_TQ    16'h0010
`define LOCK_PMA_TQ    16'h0008
`define LOCK_PCS_TQ    16'h0008

`endif

// *** verilog/reg_codec_pkg.sv ***
// Types shared by the registration message codec
package reg_codec_pkg;

   typedef enum logic [0:0] {
      TX_IDLE,
      TX_SEND
   } tx_state_type;

   typedef enum logic [0:0] {
      KIND_REGISTER,
      KIND_REG_ACK
   } msg_kind_type;

endpackage

// *** verilog/reg_codec.sv ***
// Registration message framer and parser with register port and interrupt
//
// Local design decisions: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`include "reg_codec_params.svh"

module reg_codec (
   input  wire logic        ref_clk,
   input  wire logic        sys_rst,
   input  wire logic [7:0]  addr,
   input  wire logic [31:0] wr_data,
   input  wire logic        wr_en,
   input  wire logic        rd_en,
   output logic      [31:0] rd_data,
   output logic             irq,
   output logic             tx_valid,
   input  wire logic        tx_ready,
   output logic      [7:0]  tx_data,
   output logic             tx_last,
   output logic      [15:0] tx_llid,
   input  wire logic        rx_valid,
   input  wire logic [7:0]  rx_data,
   input  wire logic        rx_last,
   output logic      [15:0] assigned_llid,
   output logic             llid_valid,
   output logic             dealloc,
   output logic      [15:0] dealloc_llid
);

   ////////////////////////////////////////////////////////////////////////////
   // State

   localparam logic [15:0] LOCK_TQ = `LOCK_PMD_TQ + `LOCK_PMA_TQ + `LOCK_PCS_TQ;

   typedef struct packed {
      reg_codec_pkg::tx_state_type tx_st;
      reg_codec_pkg::msg_kind_type kind;
      logic [5:0]                  idx;
      logic [7:0]                  tx_data;
      logic                        tx_last;
      logic [15:0]                 tx_llid;
      logic [47:0]                 s_da;
      logic [47:0]                 s_sa;
      logic [15:0]                 s_port;
      logic [7:0]                  s_flag;
      logic [15:0]                 s_sync;
      logic [7:0]                  s_grants;
      logic [31:0]                 s_ts;
      logic [47:0]                 cfg_da;
      logic [47:0]                 cfg_sa;
      logic [15:0]                 cfg_port;
      logic [7:0]                  cfg_rflag;
      logic [7:0]                  cfg_grants;
      logic [15:0]                 cfg_sync;
      logic [7:0]                  cfg_aflag;
      logic [31:0]                 cfg_ts;
      logic [`ST_WIDTH-1:0]        status;
      logic [`ST_WIDTH-1:0]        mask;
      logic [31:0]                 rd_data;
      logic [5:0]                  rx_idx;
      logic                        rx_group;
      logic [15:0]                 rx_type;
      logic [15:0]                 rx_op;
      logic [47:0]                 rx_body;
      logic [15:0]                 rx_port;
      logic [7:0]                  rx_flag;
      logic [15:0]                 rx_sync;
      logic [7:0]                  rx_grants;
      logic                        registered;
      logic [15:0]                 llid;
      logic                        dealloc;
      logic [15:0]                 dealloc_llid;
   } state_type;

   state_type q;
   state_type d;

   ////////////////////////////////////////////////////////////////////////////
   // Elaboration checks

   // Frame must hold every body field of both message kinds
   if (`FRAME_LEN < 6'd26) begin : g_bad_frame_len
      $error("frame length shorter than the message body");
   end

   // Receive minimum must reach the last body byte
   if (`RX_MIN_LEN < 6'd25) begin : g_bad_rx_min
      $error("receive minimum shorter than the message body");
   end

   // Status layout needs one bit per event
   if (`ST_WIDTH != 6) begin : g_bad_status_width
      $error("status width does not match the event list");
   end

   ////////////////////////////////////////////////////////////////////////////
   // Functions

   // Raise sync time to the receiver lock floor
   function automatic logic [15:0] eff_sync(input logic [15:0] v);
      eff_sync = (v < LOCK_TQ) ? LOCK_TQ : v;
   endfunction

   // Byte of an outgoing frame at a given position
   function automatic logic [7:0] frame_byte(input state_type s, input logic [5:0] i);
      logic [7:0] b;
      b = 8'h00;  // Pad region is zero
      case (i)
         6'd0:  b = s.s_da[47:40];
         6'd1:  b = s.s_da[39:32];
         6'd2:  b = s.s_da[31:24];
         6'd3:  b = s.s_da[23:16];
         6'd4:  b = s.s_da[15:8];
         6'd5:  b = s.s_da[7:0];
         6'd6:  b = s.s_sa[47:40];
         6'd7:  b = s.s_sa[39:32];
         6'd8:  b = s.s_sa[31:24];
         6'd9:  b = s.s_sa[23:16];
         6'd10: b = s.s_sa[15:8];
         6'd11: b = s.s_sa[7:0];
         6'd12: b = 8'(`MAC_CTRL_TYPE >> 8);
         6'd13: b = 8'(`MAC_CTRL_TYPE);
         6'd14: b = 8'h00;
         6'd15: b = (s.kind == reg_codec_pkg::KIND_REGISTER) ? 8'(`OPC_REGISTER) : 8'(`OPC_REG_ACK);
         6'd16: b = s.s_ts[31:24];
         6'd17: b = s.s_ts[23:16];
         6'd18: b = s.s_ts[15:8];
         6'd19: b = s.s_ts[7:0];
         default: begin
            if (s.kind == reg_codec_pkg::KIND_REGISTER) begin
               case (i)
                  6'd20:   b = s.s_port[15:8];
                  6'd21:   b = s.s_port[7:0];
                  6'd22:   b = s.s_flag;
                  6'd23:   b = s.s_sync[15:8];
                  6'd24:   b = s.s_sync[7:0];
                  6'd25:   b = s.s_grants;
                  default: b = 8'h00;
               endcase
            end else begin
               case (i)
                  6'd20:   b = s.s_flag;
                  6'd21:   b = s.s_port[15:8];
                  6'd22:   b = s.s_port[7:0];
                  6'd23:   b = s.s_sync[15:8];
                  6'd24:   b = s.s_sync[7:0];
                  default: b = 8'h00;
               endcase
            end
         end
      endcase
      return b;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb begin
      logic [`ST_WIDTH-1:0] ev;
      logic                 start_reg;
      logic                 start_ack;
      logic [7:0]           fl;
      logic [15:0]          rport;
      ev        = '0;
      start_reg = 1'b0;
      start_ack = 1'b0;
      fl        = 8'h00;
      rport     = 16'h0000;
      d         = q;
      d.dealloc = 1'b0;

      // Register writes
      if (wr_en) begin
         case (addr)
            `OFS_CTRL: begin
               start_reg = wr_data[`CTRL_SEND_REG];
               start_ack = wr_data[`CTRL_SEND_ACK] & ~wr_data[`CTRL_SEND_REG];
            end
            `OFS_DA_LO:     d.cfg_da[31:0]  = wr_data;
            `OFS_DA_HI:     d.cfg_da[47:32] = wr_data[15:0];
            `OFS_SA_LO:     d.cfg_sa[31:0]  = wr_data;
            `OFS_SA_HI:     d.cfg_sa[47:32] = wr_data[15:0];
            `OFS_TX_FIELDS: begin
               d.cfg_port   = wr_data[15:0];
               d.cfg_rflag  = wr_data[23:16];
               d.cfg_grants = wr_data[31:24];
            end
            `OFS_TX_SYNC: begin
               d.cfg_sync  = wr_data[15:0];
               d.cfg_aflag = wr_data[23:16];
            end
            `OFS_TIMESTAMP: d.cfg_ts = wr_data;
            `OFS_STATUS:    d.status = q.status & ~wr_data[`ST_WIDTH-1:0];
            `OFS_MASK:      d.mask   = wr_data[`ST_WIDTH-1:0];
            default: ;
         endcase
      end

      // Register reads, data one cycle later
      d.rd_data = 32'h0000_0000;
      if (rd_en) begin
         case (addr)
            `OFS_DA_LO:     d.rd_data = q.cfg_da[31:0];
            `OFS_DA_HI:     d.rd_data = {16'h0000, q.cfg_da[47:32]};
            `OFS_SA_LO:     d.rd_data = q.cfg_sa[31:0];
            `OFS_SA_HI:     d.rd_data = {16'h0000, q.cfg_sa[47:32]};
            `OFS_TX_FIELDS: d.rd_data = {q.cfg_grants, q.cfg_rflag, q.cfg_port};
            `OFS_TX_SYNC:   d.rd_data = {8'h00, q.cfg_aflag, eff_sync(q.cfg_sync)};
            `OFS_TIMESTAMP: d.rd_data = q.cfg_ts;
            `OFS_STATUS:    d.rd_data = {26'h0, q.status};
            `OFS_MASK:      d.rd_data = {26'h0, q.mask};
            `OFS_RX_FIELDS: d.rd_data = {q.rx_grants, q.rx_flag, q.rx_port};
            `OFS_RX_SYNC:   d.rd_data = {13'h0, q.registered, q.tx_st == reg_codec_pkg::TX_SEND, 1'b0, q.rx_sync};
            default:        d.rd_data = 32'h0000_0000;
         endcase
      end

      // Framer
      case (q.tx_st)
         reg_codec_pkg::TX_IDLE: begin
            if (start_reg && q.cfg_da[40]) begin
               ev[`ST_TX_REFUSED] = 1'b1;
            end else if (start_reg || start_ack) begin
               d.tx_st    = reg_codec_pkg::TX_SEND;
               d.kind     = start_reg ? reg_codec_pkg::KIND_REGISTER : reg_codec_pkg::KIND_REG_ACK;
               d.s_da     = q.cfg_da;
               d.s_sa     = q.cfg_sa;
               d.s_port   = q.cfg_port;
               d.s_flag   = start_reg ? q.cfg_rflag : q.cfg_aflag;
               d.s_sync   = eff_sync(q.cfg_sync);
               d.s_grants = q.cfg_grants;
               d.s_ts     = q.cfg_ts;
               d.tx_llid  = start_reg ? `BCAST_LLID : q.cfg_port;
               d.idx      = 6'd0;
               d.tx_last  = 1'b0;
               d.tx_data  = q.cfg_da[47:40];
            end
         end
         reg_codec_pkg::TX_SEND: begin
            // Refuse a send while a frame is on the wire
            if (start_reg || start_ack) begin
               ev[`ST_TX_REFUSED] = 1'b1;
            end
            if (tx_ready) begin
               if (q.tx_last) begin
                  d.tx_st          = reg_codec_pkg::TX_IDLE;
                  d.tx_last        = 1'b0;
                  ev[`ST_TX_DONE]  = 1'b1;
               end else begin
                  // Advance on each accepted byte
                  d.idx     = q.idx + 6'd1;
                  d.tx_data = frame_byte(q, q.idx + 6'd1);
                  d.tx_last = (q.idx + 6'd1) == (`FRAME_LEN - 6'd1);
               end
            end
         end
         default: d.tx_st = reg_codec_pkg::TX_IDLE;
      endcase

      // Parser: capture header and body bytes
      if (rx_valid) begin
         if (q.rx_idx != 6'h3F) begin
            d.rx_idx = q.rx_idx + 6'd1;
         end
         case (q.rx_idx)
            6'd0:  d.rx_group = rx_data[0];
            6'd12: d.rx_type[15:8] = rx_data;
            6'd13: d.rx_type[7:0]  = rx_data;
            6'd14: d.rx_op[15:8]   = rx_data;
            6'd15: d.rx_op[7:0]    = rx_data;
            6'd20: d.rx_body[47:40] = rx_data;
            6'd21: d.rx_body[39:32] = rx_data;
            6'd22: d.rx_body[31:24] = rx_data;
            6'd23: d.rx_body[23:16] = rx_data;
            6'd24: d.rx_body[15:8]  = rx_data;
            6'd25: d.rx_body[7:0]   = rx_data;
            default: ;  // Pad and timestamp ignored
         endcase
      end

      // Parser: classify at end of frame
      if (rx_valid && rx_last) begin
         d.rx_idx = 6'd0;
         if (q.rx_type == `MAC_CTRL_TYPE && q.rx_idx >= `RX_MIN_LEN) begin
            if (q.rx_op == `OPC_REGISTER) begin
               fl    = q.rx_body[31:24];
               rport = q.rx_body[47:32];
               if (q.rx_group) begin
                  ev[`ST_RX_BAD_DA] = 1'b1;
               end else if (fl >= `RF_REREG && fl <= `RF_NACK) begin
                  d.rx_port   = rport;
                  d.rx_flag   = fl;
                  d.rx_sync   = q.rx_body[23:8];
                  d.rx_grants = d.rx_body[7:0];
                  ev[`ST_RX_REG] = 1'b1;
                  // Deregister frees the link and pulses the release
                  if (fl == `RF_DEREG) begin
                     d.registered   = 1'b0;
                     d.llid         = 16'h0000;
                     d.dealloc      = 1'b1;
                     d.dealloc_llid = q.llid;
                     ev[`ST_RX_DEREG] = 1'b1;
                  end else if (fl == `RF_ACK) begin
                     d.registered = 1'b1;
                     d.llid       = rport;
                  end else if (fl == `RF_REREG || fl == `RF_NACK) begin
                     d.registered = 1'b0;
                  end
               end
            end else if (q.rx_op == `OPC_REG_ACK) begin
               fl = q.rx_body[47:40];
               if (fl == `AF_NACK || fl == `AF_ACK) begin
                  d.rx_flag   = fl;
                  d.rx_port   = q.rx_body[39:24];
                  d.rx_sync   = q.rx_body[23:8];
                  d.rx_grants = 8'h00;
                  ev[`ST_RX_ACK] = 1'b1;
               end
            end
         end
      end

      // Sticky events: a set wins over a same-cycle clear
      d.status = d.status | ev;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registers

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         q            <= '0;
         q.tx_st      <= reg_codec_pkg::TX_IDLE;
         q.kind       <= reg_codec_pkg::KIND_REGISTER;
         q.cfg_rflag  <= `RST_REG_FLAG;
         q.cfg_aflag  <= `RST_ACK_FLAG;
         q.cfg_sync   <= `RST_SYNC;
         q.cfg_grants <= `RST_GRANTS;
         q.mask       <= `RST_MASK;
      end else begin
         q <= d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs

   assign rd_data       = q.rd_data;
   assign irq           = |(q.status & q.mask);
   assign tx_valid      = q.tx_st == reg_codec_pkg::TX_SEND;
   assign tx_data       = q.tx_data;
   assign tx_last       = q.tx_last;
   assign tx_llid       = q.tx_llid;
   assign assigned_llid = q.llid;
   assign llid_valid    = q.registered;
   assign dealloc       = q.dealloc;
   assign dealloc_llid  = q.dealloc_llid;

endmodule // reg_codec

// *** bench/reg_codec_properties.sv ***
// Port checker for the registration message codec
`timescale 1ns/1ps
module reg_codec_checker (
   input wire logic        ref_clk,
   input wire logic        sys_rst,
   input wire logic        irq,
   input wire logic        tx_valid,
   input wire logic        tx_ready,
   input wire logic [7:0]  tx_data,
   input wire logic        tx_last,
   input wire logic [15:0] tx_llid,
   input wire logic [15:0] assigned_llid,
   input wire logic        llid_valid,
   input wire logic        dealloc
);
   logic [5:0] idx_q;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
////////////////////////////////////////
   // Index of the byte on offer
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) idx_q <= 6'h00;
      else if (!tx_valid) idx_q <= 6'h00;
      else if (tx_ready) idx_q <= idx_q + 6'h01;
   end
////////////////////////////////////////
   // Frame shape and tags
   property p_len; tx_valid |-> tx_last == (idx_q == 6'h3B); endproperty
   property p_end; tx_valid && tx_ready && tx_last |=> !tx_valid; endproperty
   property p_hold; tx_valid && !tx_ready |=> tx_valid && $stable(tx_data) && $stable(tx_llid); endproperty
   property p_opc; tx_valid && idx_q == 6'h0F |-> tx_data inside {8'h05, 8'h06}; endproperty
   property p_bcast; tx_valid && idx_q == 6'h0F && tx_data == 8'h05 |-> tx_llid == 16'h7FFF; endproperty
   property p_ucast; tx_valid && idx_q == 6'h0F && tx_data == 8'h06 |-> tx_llid != 16'h7FFF; endproperty
   property p_pad; tx_valid && idx_q >= 6'h1A |-> tx_data == 8'h00; endproperty
   property p_da; tx_valid && idx_q == 6'h00 && tx_llid == 16'h7FFF |-> !tx_data[0]; endproperty
   property p_dealloc; dealloc |-> !llid_valid && assigned_llid == 16'h0000 ##1 !dealloc; endproperty
   a_len: assert property (p_len) else $error("last flag off the final byte");
   a_end: assert property (p_end) else $error("valid held after last byte");
   a_hold: assert property (p_hold) else $error("byte changed while stalled");
   a_opc: assert property (p_opc) else $error("bad opcode byte");
   a_bcast: assert property (p_bcast) else $error("register frame not broadcast");
   a_ucast: assert property (p_ucast) else $error("ack frame not unicast");
   a_pad: assert property (p_pad) else $error("pad byte not zero");
   a_da: assert property (p_da) else $error("group destination sent");
   a_dealloc: assert property (p_dealloc) else $error("bad dealloc pulse");
   c_frame: cover property (tx_valid && tx_ready && tx_last);
   c_dealloc: cover property (dealloc);
   c_irq: cover property (irq);
endmodule // reg_codec_checker

bind reg_codec reg_codec_checker u_reg_codec_checker (
   .ref_clk(ref_clk), .sys_rst(sys_rst), .irq(irq), .tx_valid(tx_valid), .tx_ready(tx_ready),
   .tx_data(tx_data), .tx_last(tx_last), .tx_llid(tx_llid), .assigned_llid(assigned_llid),
   .llid_valid(llid_valid), .dealloc(dealloc)
);

// *** bench/peer_mac.sv ***
// Peer MAC model: sinks sent frames, sources received frames
`timescale 1ns/1ps
module peer_mac (
   input  wire logic       ref_clk,
   input  wire logic       slow,
   input  wire logic       tx_valid,
   output logic            tx_ready,
   input  wire logic [7:0] tx_data,
   output logic            rx_valid,
   output logic [7:0]      rx_data,
   output logic            rx_last
);
   logic [7:0] got [$];
   logic [1:0] stall_q = 2'h0;
   initial begin
      rx_valid = 1'b0;
      rx_data = 8'hA5;
      rx_last = 1'b0;
   end
////////////////////////////////////////
   // Capture accepted bytes; stall three of four cycles when slow
   always @(posedge ref_clk) begin
      if (tx_valid && tx_ready) got.push_back(tx_data);
      stall_q <= stall_q + 2'h1;
      tx_ready <= !slow || stall_q == 2'h3;
   end
   // Whole frame, byte by byte, pad ignored by receiver
   task send(input logic [7:0] f [60]);
      for (int i = 0; i < 60; i++) begin
         @(posedge ref_clk);
         rx_valid <= 1'b1;
         rx_data <= f[i];
         rx_last <= (i == 59);
      end
      @(posedge ref_clk);
      rx_valid <= 1'b0;
      rx_last <= 1'b0;
      rx_data <= ~f[59]; // Released line shows no stale byte
   endtask
endmodule // peer_mac

// *** bench/mpcp_registration_message_codec_test.sv ***
// Testbench for the registration message codec
`timescale 1ns/1ps
`include "reg_codec_params.svh"
module mpcp_registration_message_codec_test;
   localparam logic [47:0] src_mac = 48'h021122334455;
   localparam logic [31:0] stamp   = 32'h12345678;
   localparam logic [15:0] floor   = `LOCK_PMD_TQ + `LOCK_PMA_TQ + `LOCK_PCS_TQ;
   logic        ref_clk = 1'b0, sys_rst = 1'b1, wr_en = 1'b0, rd_en = 1'b0, slow = 1'b0, mv = 1'b0;
   logic [7:0]  addr = 8'h00, gr, tx_data, rx_data;
   logic [31:0] wr_data = 32'h0, rd_data, d;
   logic        irq, tx_valid, tx_ready, tx_last, rx_valid, rx_last, llid_valid, dealloc;
   logic [15:0] tx_llid, assigned_llid, dealloc_llid, port, sync;
   logic [47:0] da;
   logic [7:0]  fr [60];
   logic [7:0]  rf [7] = '{8'h03, 8'h02, 8'h05, 8'h00, 8'h01, 8'h03, 8'h04};
   logic [7:0]  ra [5] = '{`OFS_STATUS, `OFS_MASK, `OFS_TX_FIELDS, `OFS_TX_SYNC, 8'h40};
   logic [31:0] rv [5] = '{32'h0, 32'h0, 32'h00030000, 32'h00010020, 32'h0};
   integer      seed = 80066, failures = 0, num_checks = 0;

   // Clock
   always #2.5 ref_clk = ~ref_clk;

   reg_codec u_reg_codec (
      .ref_clk(ref_clk), .sys_rst(sys_rst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
      .rd_en(rd_en), .rd_data(rd_data), .irq(irq), .tx_valid(tx_valid), .tx_ready(tx_ready),
      .tx_data(tx_data), .tx_last(tx_last), .tx_llid(tx_llid), .rx_valid(rx_valid),
      .rx_data(rx_data), .rx_last(rx_last), .assigned_llid(assigned_llid),
      .llid_valid(llid_valid), .dealloc(dealloc), .dealloc_llid(dealloc_llid)
   );
   peer_mac u_peer_mac (
      .ref_clk(ref_clk), .slow(slow), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
      .rx_valid(rx_valid), .rx_data(rx_data), .rx_last(rx_last)
   );
////////////////////////////////////////
   // Compare and count
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         failures++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task give_verdict;
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // Register bus cycles
   task wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge ref_clk);
      addr <= a;
      wr_data <= v;
      wr_en <= 1'b1;
      @(posedge ref_clk);
      wr_en <= 1'b0;
   endtask
   task rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge ref_clk);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge ref_clk);
      rd_en <= 1'b0;
      #1 v = rd_data;
   endtask
   // Reference frame from the field layout
   task mk(input logic ack, input logic [7:0] f, input logic [15:0] s);
      for (int i = 0; i < 60; i++) fr[i] = 8'h00;
      for (int i = 0; i < 6; i++) fr[i] = da[47 - 8 * i -: 8];
      for (int i = 0; i < 6; i++) fr[6 + i] = src_mac[47 - 8 * i -: 8];
      {fr[12], fr[13], fr[14], fr[15]} = {`MAC_CTRL_TYPE, ack ? `OPC_REG_ACK : `OPC_REGISTER};
      {fr[16], fr[17], fr[18], fr[19]} = stamp;
      if (ack) {fr[20], fr[21], fr[22]} = {f, port};
      else {fr[20], fr[21], fr[22], fr[25]} = {port, f, gr};
      {fr[23], fr[24]} = s;
   endtask
////////////////////////////////////////
   // Send one frame and compare every byte
   task tx(input logic ack, input logic [7:0] f);
      int n;
      port = 16'($random(seed)) & 16'h0FFF;
      sync = 16'($random(seed)) & 16'h003F;
      gr = 8'($random(seed));
      da = {16'($random(seed)), 32'($random(seed))};
      da[40] = 1'b0;
      wr(`OFS_MASK, ack ? 32'h0 : 32'h1);
      wr(`OFS_DA_LO, da[31:0]);
      wr(`OFS_DA_HI, {16'h0000, da[47:32]});
      wr(`OFS_TX_FIELDS, {gr, f, port});
      wr(`OFS_TX_SYNC, {8'h00, f, sync});
      mk(ack, f, sync < floor ? floor : sync);
      wr(`OFS_CTRL, ack ? 32'h2 : 32'h1);
      n = 0;
      while ((u_peer_mac.got.size() < 60 || tx_valid) && n < 1000) begin
         @(posedge ref_clk);
         n++;
      end
      chk(32'(u_peer_mac.got.size()), 32'h3C);
      for (int i = 0; i < 60; i++) chk(32'(u_peer_mac.got[i]), 32'(fr[i]));
      chk(32'(tx_llid), ack ? 32'(port) : 32'(`BCAST_LLID));
      u_peer_mac.got.delete();
      #1 chk(32'(irq), 32'(!ack));
      rd(`OFS_STATUS, d);
      chk(d, 32'h1);
      wr(`OFS_STATUS, 32'h3F);
   endtask
   // Receive one frame and compare the outcome
   task rx(input logic ack, input logic [7:0] f, input logic bad);
      logic [31:0] st;
      logic ok;
      sync = 16'($random(seed));
      gr = 8'($random(seed));
      da[40] = bad;
      mk(ack, f, sync);
      ok = ack ? f < 8'h02 : (f != 8'h00 && f < 8'h05);
      st = !ok ? 32'h0 : ack ? 32'h4 : bad ? 32'h20 : f == 8'h02 ? 32'hA : 32'h2;
      u_peer_mac.send(fr);
      #1 chk(32'(dealloc), 32'(st == 32'hA));
      if (ok && !ack && !bad) mv = f == 8'h03;
      chk(32'(llid_valid), 32'(mv));
      if (mv) chk(32'(assigned_llid), 32'(port));
      if (st == 32'hA) chk(32'(dealloc_llid), 32'(port));
      rd(`OFS_STATUS, d);
      chk(d, st);
      if (st != 32'h0 && st != 32'h20) begin
         rd(`OFS_RX_FIELDS, d);
         chk(d, {ack ? 8'h00 : gr, f, port});
         rd(`OFS_RX_SYNC, d);
         chk(32'(d[15:0]), 32'(sync));
         chk(32'(d[18]), 32'(mv));
      end
      wr(`OFS_STATUS, 32'h3F);
   endtask
////////////////////////////////////////
   // Main sequence
   initial begin
      repeat (20) @(posedge ref_clk);
      sys_rst <= 1'b0;
      for (int i = 0; i < 5; i++) begin
         rd(ra[i], d);
         chk(d, rv[i]);
      end
      $display("test reset values done");
      wr(`OFS_SA_LO, src_mac[31:0]);
      wr(`OFS_SA_HI, {16'h0000, src_mac[47:32]});
      wr(`OFS_TIMESTAMP, stamp);
      for (int i = 1; i < 5; i++) tx(1'b0, 8'(i));
      slow <= 1'b1;
      tx(1'b1, 8'h00);
      tx(1'b1, 8'h01);
      slow <= 1'b0;
      $display("test transmit done");
      wr(`OFS_DA_HI, 32'h00000100);
      wr(`OFS_CTRL, 32'h1);
      repeat (70) @(posedge ref_clk);
      chk(32'(u_peer_mac.got.size()), 32'h0);
      rd(`OFS_STATUS, d);
      chk(d, 32'h10);
      wr(`OFS_STATUS, 32'h3F);
      rd(`OFS_STATUS, d);
      chk(d, 32'h0);
      $display("test refusal done");
      for (int i = 0; i < 7; i++) rx(1'b0, rf[i], 1'b0);
      for (int i = 0; i < 3; i++) rx(1'b1, 8'(i), 1'b0);
      rx(1'b0, 8'h03, 1'b1);
      $display("test receive done");
      give_verdict;
   end
   // Watchdog, far beyond the expected run
   initial begin
      #100000;
      failures++;
      give_verdict;
   end
endmodule // mpcp_registration_message_codec_test
